//--- test/lsx_exec_sva.sv
`timescale 1ns/1ps
module lsx_exec_sva
	import lsx_pkg::*;
(
	// clock and reset
	input wire logic               CLK_IN,
	input wire logic               NRST_IN,
	input wire logic               CE_IN,
	// instruction port
	input wire logic               START_IN,
	input wire logic [3:0]         OP_IN,
	input wire logic               BUSY_OUT,
	input wire logic               DONE_OUT,
	input wire logic               SKIP_OUT,
	input wire logic               ILLEGAL_OUT,
	// program and register ports
	input wire logic               PROG_RD_OUT,
	input wire logic [PADDR_W-1:0] PROG_ADDR_OUT,
	input wire logic               REG_RD_IN,
	input wire logic [7:0]         REG_RDATA_OUT
);
	logic taken;
	logic is_last;

	// a start counts only while idle
	assign taken   = CE_IN && START_IN && !BUSY_OUT;
	assign is_last = (OP_IN == 4'h4) || (OP_IN == 4'h6);

	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!NRST_IN);

	// ---------------------------------------------------------------
	// timing of each instruction kind
	// ---------------------------------------------------------------
	a_busy_after_start:
		assert property (taken |=> BUSY_OUT)
		else $error("busy did not rise after start");
	a_done_pulse:
		assert property (DONE_OUT |=> !DONE_OUT)
		else $error("done longer than one cycle");
	a_done_ends_busy:
		assert property (DONE_OUT |-> !BUSY_OUT && $past(BUSY_OUT))
		else $error("done without busy before it");
	a_skip_with_done:
		assert property (SKIP_OUT |-> DONE_OUT)
		else $error("skip without done");
	a_skip_timing:
		assert property (taken && OP_IN <= 4'h2 |->
			(##2 (DONE_OUT && !SKIP_OUT)) or (##3 (DONE_OUT && SKIP_OUT)))
		else $error("skip op took wrong cycle count");
	a_table_timing:
		assert property (taken && OP_IN >= 4'h3 && OP_IN <= 4'h6 |->
			##2 PROG_RD_OUT ##1 !PROG_RD_OUT ##1 DONE_OUT)
		else $error("table read took wrong cycle count");
	a_last_page:
		assert property (taken && is_last |->
			##2 (PROG_ADDR_OUT[15:8] == LAST_PAGE))
		else $error("last page read used wrong page");
	a_xor_timing:
		assert property (taken && (OP_IN == 4'h7 || OP_IN == 4'h8) |->
			##2 (DONE_OUT && !SKIP_OUT && !ILLEGAL_OUT))
		else $error("xor took wrong cycle count");
	a_illegal_op:
		assert property (taken && OP_IN > 4'h8 |->
			##2 (DONE_OUT && ILLEGAL_OUT))
		else $error("unknown op not flagged");
	a_rdata_idle:
		assert property (!REG_RD_IN |=> REG_RDATA_OUT == 8'h00)
		else $error("read data not zero without read");
endmodule : lsx_exec_sva

bind lsx_exec lsx_exec_sva u_sva (
	.CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .CE_IN(CE_IN),
	.START_IN(START_IN), .OP_IN(OP_IN), .BUSY_OUT(BUSY_OUT),
	.DONE_OUT(DONE_OUT), .SKIP_OUT(SKIP_OUT), .ILLEGAL_OUT(ILLEGAL_OUT),
	.PROG_RD_OUT(PROG_RD_OUT), .PROG_ADDR_OUT(PROG_ADDR_OUT),
	.REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT)
);

//--- test/lsx_exec_tb.sv
`timescale 1ns/1ps
module lsx_exec_tb;
	import lsx_pkg::*;

	logic               clk, nrst, start, wr, rd;
	logic               busy, done, skip, ill, prd;
	logic [3:0]         op;
	logic [7:0]         addr, wdata, rdata;
	logic [2:0]         bsel;
	logic [PADDR_W-1:0] paddr;
	logic [PROG_W-1:0]  pdata, w;
	logic [BADDR_W-1:0] raddr;
	logic [7:0]         lo;
	logic               got_ill;
	int                 fail_count, checks, n;

	lsx_exec uut (
		.CLK_IN(clk), .NRST_IN(nrst), .CE_IN(1'b1),
		.START_IN(start), .OP_IN(op), .ADDR_IN(addr), .BIT_IN(bsel),
		.BUSY_OUT(busy), .DONE_OUT(done), .SKIP_OUT(skip),
		.ILLEGAL_OUT(ill), .PROG_RD_OUT(prd), .PROG_ADDR_OUT(paddr),
		.PROG_DATA_IN(pdata), .REG_ADDR_IN(raddr), .REG_WDATA_IN(wdata),
		.REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	function automatic logic [15:0] word_of(input logic [15:0] a);
		return {a[7:0] ^ 8'h5A, a[15:8] ^ 8'hC3};
	endfunction

	// program word valid one cycle only, churns otherwise
	always @(posedge clk) begin
		if (prd) pdata <= word_of(paddr);
		else pdata <= ~pdata;
	end

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task wreg(input logic [8:0] a, input logic [7:0] d);
		@(posedge clk);
		raddr <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask : wreg

	task rreg(input logic [8:0] a, input logic [7:0] e);
		@(posedge clk);
		raddr <= a;
		rd    <= 1'b1;
		@(posedge clk);
		rd    <= 1'b0;
		#1;
		chk(rdata, e);
	endtask : rreg

	// cycle count and skip flag both judged; three cycles means skipped
	task exec(input logic [3:0] o, input logic [7:0] a,
		input logic [2:0] b, input int exp_n);
		@(posedge clk);
		start <= 1'b1;
		op    <= o;
		addr  <= a;
		bsel  <= b;
		@(posedge clk);
		start <= 1'b0;
		for (n = 1; n < 9; n++) begin
			#1;
			if (done === 1'b1) break;
			@(posedge clk);
		end
		got_ill = ill;
		chk(8'(n), 8'(exp_n));
		chk(8'(skip), 8'(exp_n == 3));
	endtask : exec

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task t_regs;
		for (int i = 0; i < 5; i++) rreg(9'(i), 8'h00);
		wreg(9'h005, 8'hFF);
		rreg(9'h005, 8'h00);
	endtask : t_regs

	task t_skip_zero;
		wreg(OFF_ACC, 8'h33);
		wreg(OFF_STATUS, 8'h01);
		wreg(9'h110, 8'h00);
		exec(OP_SKIP_IF_ZERO, 8'h10, 3'h0, 3);
		rreg(9'h110, 8'h00);
		rreg(OFF_ACC, 8'h33);
		rreg(OFF_STATUS, 8'h05);
		wreg(9'h110, 8'h5A);
		exec(OP_SKIP_IF_ZERO, 8'h10, 3'h0, 2);
		rreg(9'h110, 8'h5A);
	endtask : t_skip_zero

	task t_copy;
		wreg(9'h111, 8'h00);
		exec(OP_COPY_SKIP_IF_ZERO, 8'h11, 3'h0, 3);
		rreg(OFF_ACC, 8'h00);
		wreg(9'h111, 8'h80);
		exec(OP_COPY_SKIP_IF_ZERO, 8'h11, 3'h0, 2);
		rreg(OFF_ACC, 8'h80);
	endtask : t_copy

	task t_bit;
		wreg(9'h112, 8'h7E);
		for (int i = 0; i < 8; i++)
			exec(OP_SKIP_IF_BIT_ZERO, 8'h12, 3'(i),
				(i == 0 || i == 7) ? 3 : 2);
	endtask : t_bit

	// pointer low at FF so the incrementing forms wrap to 00
	task t_table;
		for (int i = 0; i < 4; i++) begin
			wreg(OFF_PTR_LO, 8'hFF);
			wreg(OFF_PTR_HI, 8'h12);
			lo = (i >= 2) ? 8'h00 : 8'hFF;
			w  = word_of({(i % 2) ? LAST_PAGE : 8'h12, lo});
			exec(4'(4'h3 + i), 8'h20, 3'h0, 4);
			rreg(9'h120, w[7:0]);
			rreg(OFF_TAB_HI, w[15:8]);
			rreg(OFF_PTR_LO, lo);
		end
	endtask : t_table

	task t_xor;
		wreg(OFF_ACC, 8'h3C);
		wreg(OFF_STATUS, 8'h00);
		wreg(9'h130, 8'h3C);
		exec(OP_XOR_TO_ACC, 8'h30, 3'h0, 2);
		rreg(OFF_ACC, 8'h00);
		rreg(OFF_STATUS, 8'h01);
		rreg(9'h130, 8'h3C);
		wreg(OFF_ACC, 8'h0F);
		wreg(9'h131, 8'hF0);
		exec(OP_XOR_TO_MEM, 8'h31, 3'h0, 2);
		rreg(9'h131, 8'hFF);
		rreg(OFF_ACC, 8'h0F);
		rreg(OFF_STATUS, 8'h00);
		exec(4'hF, 8'h31, 3'h0, 2);
		chk(8'(got_ill), 8'h01);
	endtask : t_xor

	task close_out;
		$display("checks %0d errors %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : close_out

	initial begin
		#100000;
		fail_count++;
		close_out;
	end

	initial begin
		{nrst, start, wr, rd, op, addr, bsel} = '0;
		{raddr, wdata, pdata} = '0;
		fail_count = 0;
		checks = 0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		t_regs;
		t_skip_zero;
		t_copy;
		t_bit;
		t_table;
		t_xor;
		close_out;
	end
endmodule : lsx_exec_tb

//--- verilog/lsx_alu.sv
`timescale 1ns/1ps
module lsx_alu
	import lsx_pkg::*;
(
	lsx_if.alu u
);
	assign u.xor_res  = u.acc ^ u.mem;
	assign u.xor_zero = (u.xor_res == 8'h00);
	assign u.mem_zero = (u.mem == 8'h00);
	assign u.bit_zero = ~u.mem[u.bit_sel];
endmodule : lsx_alu

//--- verilog/lsx_exec.sv
// Notes on behaviour
// - zero-skip rewrites the byte unchanged and skips when it is zero.
// - a taken skip adds a dummy cycle, three cycles in all.
// - copy-and-skip loads the byte into the accumulator, skips if zero.
// - bit-test skip skips only when the selected bit of the byte is zero.
// - paged table read addresses program memory with both pointer bytes.
// - last-page table read uses the last page and the pointer low byte.
// - incrementing paged table read bumps the pointer low first.
// - incrementing last-page table read bumps the pointer low byte first.
// - xor-to-accumulator writes the accumulator and only the Z flag.
// - xor-to-memory stores the result in data memory, only Z changes.
`timescale 1ns/1ps
module lsx_exec
	import lsx_pkg::*;
(
	// clock, reset, enable
	input  wire logic               CLK_IN,
	input  wire logic               NRST_IN,
	input  wire logic               CE_IN,
	// instruction issue
	input  wire logic               START_IN,
	input  wire logic [3:0]         OP_IN,
	input  wire logic [7:0]         ADDR_IN,
	input  wire logic [2:0]         BIT_IN,
	// instruction status
	output logic                    BUSY_OUT,
	output logic                    DONE_OUT,
	output logic                    SKIP_OUT,
	output logic                    ILLEGAL_OUT,
	// program memory read port
	output logic                    PROG_RD_OUT,
	output logic [PADDR_W-1:0]      PROG_ADDR_OUT,
	input  wire logic [PROG_W-1:0]  PROG_DATA_IN,
	// register port
	input  wire logic [BADDR_W-1:0] REG_ADDR_IN,
	input  wire logic [7:0]         REG_WDATA_IN,
	input  wire logic               REG_WR_IN,
	input  wire logic               REG_RD_IN,
	output logic [7:0]              REG_RDATA_OUT
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	lsx_state_e  state_r;
	lsx_state_e  state_nxt;
	lsx_op_e     op_r;
	logic [7:0]  addr_r;
	logic [2:0]  bit_r;
	logic [7:0]  acc_r;
	logic [7:0]  ptr_lo_r;
	logic [7:0]  ptr_hi_r;
	logic [7:0]  tab_hi_r;
	logic        z_r;
	logic        skip_last_r;
	logic        busy_r;
	logic        done_r;
	logic        skip_r;
	logic        illegal_r;
	logic        prog_rd_r;
	logic [15:0] prog_addr_r;
	logic [7:0]  rdata_r;
	logic [7:0]  dmem [0:DMEM_N-1];

	lsx_if u_if ();

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	lsx_alu u_alu (
		.u (u_if)
	);

	lsx_ptr u_ptr (
		.u (u_if)
	);

	wire [7:0] mem_val;
	assign mem_val = dmem[addr_r];

	assign u_if.acc     = acc_r;
	assign u_if.mem     = mem_val;
	assign u_if.bit_sel = bit_r;
	assign u_if.ptr_lo  = ptr_lo_r;
	assign u_if.ptr_hi  = ptr_hi_r;

	// ---------------------------------------------------------------
	// operation decode
	// ---------------------------------------------------------------
	wire op_sz;
	wire op_sza;
	wire op_szb;
	wire op_tab;
	wire op_xa;
	wire op_xm;
	wire op_known;

	assign op_sz    = (op_r == OP_SKIP_IF_ZERO);
	assign op_sza   = (op_r == OP_COPY_SKIP_IF_ZERO);
	assign op_szb   = (op_r == OP_SKIP_IF_BIT_ZERO);
	assign op_tab   = (op_r == OP_TABLE_PAGED)
	                | (op_r == OP_TABLE_LAST)
	                | (op_r == OP_INCR_TABLE_PAGED)
	                | (op_r == OP_INCR_TABLE_LAST);
	assign op_xa    = (op_r == OP_XOR_TO_ACC);
	assign op_xm    = (op_r == OP_XOR_TO_MEM);
	assign op_known = op_sz | op_sza | op_szb | op_tab | op_xa | op_xm;

	assign u_if.incr  = (op_r == OP_INCR_TABLE_PAGED)
	                  | (op_r == OP_INCR_TABLE_LAST);
	assign u_if.paged = (op_r == OP_TABLE_PAGED)
	                  | (op_r == OP_INCR_TABLE_PAGED);

	wire in_idle;
	wire in_exec;
	wire in_tdata;
	wire in_dummy;
	wire accept;

	assign in_idle  = (state_r == ST_IDLE);
	assign in_exec  = (state_r == ST_EXEC);
	assign in_tdata = (state_r == ST_TDATA);
	assign in_dummy = (state_r == ST_DUMMY);
	// a start while busy is dropped; the issuer waits for done
	assign accept   = in_idle & START_IN;

	// ---------------------------------------------------------------
	// skip decision
	// ---------------------------------------------------------------
	wire skip_take;
	assign skip_take = in_exec & ((op_sz  & u_if.mem_zero)
	                            | (op_sza & u_if.mem_zero)
	                            | (op_szb & u_if.bit_zero));

	// ---------------------------------------------------------------
	// core writes (dummy cycle drives none of these)
	// ---------------------------------------------------------------
	wire       core_mem_we;
	wire [7:0] core_mem_wd;
	wire       core_acc_we;
	wire [7:0] core_acc_wd;
	wire       core_z_we;
	wire       core_ptr_we;
	wire       core_tab_we;

	// zero-skip rewrites the byte it read, value unchanged
	assign core_mem_we = (in_exec & (op_sz | op_xm))
	                   | in_tdata;
	assign core_mem_wd = in_tdata ? PROG_DATA_IN[7:0]
	                   : op_xm    ? u_if.xor_res
	                   : mem_val;
	assign core_acc_we = in_exec & (op_sza | op_xa);
	assign core_acc_wd = op_xa ? u_if.xor_res : mem_val;
	assign core_z_we   = in_exec & (op_xa | op_xm);
	assign core_ptr_we  = in_exec & u_if.incr;
	assign core_tab_we  = in_tdata;

	// ---------------------------------------------------------------
	// register port decode
	// ---------------------------------------------------------------
	wire sel_mem;
	wire sel_acc;
	wire sel_plo;
	wire sel_phi;
	wire sel_thi;
	wire sel_stat;

	assign sel_mem  = REG_ADDR_IN[MEM_SEL_BIT];
	assign sel_acc  = ~sel_mem & (REG_ADDR_IN == OFF_ACC);
	assign sel_plo  = ~sel_mem & (REG_ADDR_IN == OFF_PTR_LO);
	assign sel_phi  = ~sel_mem & (REG_ADDR_IN == OFF_PTR_HI);
	assign sel_thi  = ~sel_mem & (REG_ADDR_IN == OFF_TAB_HI);
	assign sel_stat = ~sel_mem & (REG_ADDR_IN == OFF_STATUS);

	wire [7:0] stat_val;
	assign stat_val = {5'h00, skip_last_r, busy_r, z_r};

	wire [7:0] rd_mux;
	assign rd_mux = sel_mem  ? dmem[REG_ADDR_IN[7:0]]
	              : sel_acc  ? acc_r
	              : sel_plo  ? ptr_lo_r
	              : sel_phi  ? ptr_hi_r
	              : sel_thi  ? tab_hi_r
	              : sel_stat ? stat_val
	              : 8'h00;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (START_IN) begin
					state_nxt = ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (op_tab) begin
					state_nxt = ST_TREAD;
				end else if (skip_take) begin
					state_nxt = ST_DUMMY;
				end else begin
					state_nxt = ST_IDLE;
				end
			end
			ST_TREAD: begin
				state_nxt = ST_TDATA;
			end
			ST_TDATA: begin
				state_nxt = ST_IDLE;
			end
			ST_DUMMY: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	wire finish;
	assign finish = (in_exec & ~op_tab & ~skip_take) | in_tdata | in_dummy;

	// ---------------------------------------------------------------
	// sequencer registers
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			state_r <= ST_IDLE;
			op_r    <= OP_SKIP_IF_ZERO;
			addr_r  <= 8'h00;
			bit_r   <= 3'h0;
		end else if (CE_IN) begin
			state_r <= state_nxt;
			if (accept) begin
				op_r   <= lsx_op_e'(OP_IN);
				addr_r <= ADDR_IN;
				bit_r  <= BIT_IN;
			end
		end
	end

	// ---------------------------------------------------------------
	// status outputs
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			busy_r      <= 1'b0;
			done_r      <= 1'b0;
			skip_r      <= 1'b0;
			illegal_r   <= 1'b0;
			skip_last_r <= 1'b0;
		end else if (CE_IN) begin
			busy_r    <= (state_nxt != ST_IDLE);
			done_r    <= finish;
			skip_r    <= in_dummy;
			illegal_r <= in_exec & ~op_known;
			if (finish) begin
				skip_last_r <= in_dummy;
			end
		end
	end

	// ---------------------------------------------------------------
	// program memory request
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			prog_rd_r   <= 1'b0;
			prog_addr_r <= 16'h0000;
		end else if (CE_IN) begin
			prog_rd_r <= in_exec & op_tab;
			if (in_exec & op_tab) begin
				prog_addr_r <= u_if.prog_addr;
			end
		end
	end

	// ---------------------------------------------------------------
	// architectural registers; core update wins over the port
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			acc_r  <= RST_ACC;
			z_r    <= 1'b0;
		end else if (CE_IN) begin
			if (core_acc_we) begin
				acc_r <= core_acc_wd;
			end else if (REG_WR_IN & sel_acc) begin
				acc_r <= REG_WDATA_IN;
			end
			if (core_z_we) begin
				z_r <= u_if.xor_zero;
			end else if (REG_WR_IN & sel_stat) begin
				z_r <= REG_WDATA_IN[STAT_Z_BIT];
			end
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			ptr_lo_r <= RST_PTR_LO;
			ptr_hi_r <= RST_PTR_HI;
			tab_hi_r <= RST_TAB_HI;
		end else if (CE_IN) begin
			if (core_ptr_we) begin
				ptr_lo_r <= u_if.ptr_lo_nxt;
			end else if (REG_WR_IN & sel_plo) begin
				ptr_lo_r <= REG_WDATA_IN;
			end
			if (REG_WR_IN & sel_phi) begin
				ptr_hi_r <= REG_WDATA_IN;
			end
			if (core_tab_we) begin
				tab_hi_r <= PROG_DATA_IN[15:8];
			end else if (REG_WR_IN & sel_thi) begin
				tab_hi_r <= REG_WDATA_IN;
			end
		end
	end

	// ---------------------------------------------------------------
	// data memory; contents are not cleared by reset
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (NRST_IN && CE_IN) begin
			if (core_mem_we) begin
				dmem[addr_r] <= core_mem_wd;
			end else if (REG_WR_IN & sel_mem) begin
				dmem[REG_ADDR_IN[7:0]] <= REG_WDATA_IN;
			end
		end
	end

	// ---------------------------------------------------------------
	// read data, valid only in the cycle after the strobe
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			rdata_r <= 8'h00;
		end else if (CE_IN) begin
			rdata_r <= REG_RD_IN ? rd_mux : 8'h00;
		end
	end

	assign BUSY_OUT      = busy_r;
	assign DONE_OUT      = done_r;
	assign SKIP_OUT      = skip_r;
	assign ILLEGAL_OUT   = illegal_r;
	assign PROG_RD_OUT   = prog_rd_r;
	assign PROG_ADDR_OUT = prog_addr_r;
	assign REG_RDATA_OUT = rdata_r;

endmodule : lsx_exec

//--- verilog/lsx_if.sv
`timescale 1ns/1ps
interface lsx_if;
	import lsx_pkg::*;

	logic [7:0]  acc;
	logic [7:0]  mem;
	logic [2:0]  bit_sel;
	logic [7:0]  xor_res;
	logic        xor_zero;
	logic        mem_zero;
	logic        bit_zero;
	logic [7:0]  ptr_lo;
	logic [7:0]  ptr_hi;
	logic        incr;
	logic        paged;
	logic [7:0]  ptr_lo_nxt;
	logic [15:0] prog_addr;

	modport core (
		output acc, mem, bit_sel, ptr_lo, ptr_hi, incr, paged,
		input  xor_res, xor_zero, mem_zero, bit_zero, ptr_lo_nxt, prog_addr
	);
	modport alu (
		input  acc, mem, bit_sel,
		output xor_res, xor_zero, mem_zero, bit_zero
	);
	modport ptr (
		input  ptr_lo, ptr_hi, incr, paged,
		output ptr_lo_nxt, prog_addr
	);
endinterface : lsx_if

//--- verilog/lsx_pkg.sv
package lsx_pkg;

	// ---------------------------------------------------------------
	// widths
	// ---------------------------------------------------------------
	localparam int DATA_W  = 8;
	localparam int PROG_W  = 16;
	localparam int PADDR_W = 16;
	localparam int BADDR_W = 9;
	localparam int DMEM_N  = 256;

	// ---------------------------------------------------------------
	// register map (byte index on the register port)
	// ---------------------------------------------------------------
	localparam logic [8:0] OFF_ACC    = 9'h000;
	localparam logic [8:0] OFF_PTR_LO = 9'h001;
	localparam logic [8:0] OFF_PTR_HI = 9'h002;
	localparam logic [8:0] OFF_TAB_HI = 9'h003;
	localparam logic [8:0] OFF_STATUS = 9'h004;
	// data memory window: bit 8 set selects a byte of data memory
	localparam int         MEM_SEL_BIT = 8;

	// status fields
	localparam int STAT_Z_BIT    = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_SKIP_BIT = 2;

	// reset values
	localparam logic [7:0] RST_ACC    = 8'h00;
	localparam logic [7:0] RST_PTR_LO = 8'h00;
	localparam logic [7:0] RST_PTR_HI = 8'h00;
	localparam logic [7:0] RST_TAB_HI = 8'h00;

	// high byte of the program address for last-page table reads
	localparam logic [7:0] LAST_PAGE = 8'hFF;

	// ---------------------------------------------------------------
	// operations
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_SKIP_IF_ZERO      = 4'h0,
		OP_COPY_SKIP_IF_ZERO = 4'h1,
		OP_SKIP_IF_BIT_ZERO  = 4'h2,
		OP_TABLE_PAGED       = 4'h3,
		OP_TABLE_LAST        = 4'h4,
		OP_INCR_TABLE_PAGED  = 4'h5,
		OP_INCR_TABLE_LAST   = 4'h6,
		OP_XOR_TO_ACC        = 4'h7,
		OP_XOR_TO_MEM        = 4'h8
	} lsx_op_e;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_EXEC  = 3'h1,
		ST_TREAD = 3'h2,
		ST_TDATA = 3'h3,
		ST_DUMMY = 3'h4
	} lsx_state_e;

endpackage : lsx_pkg

//--- verilog/lsx_ptr.sv
`timescale 1ns/1ps
module lsx_ptr
	import lsx_pkg::*;
(
	lsx_if.ptr u
);
	wire [7:0] page;

	// pre-increment feeds the address, so the fetch sees the new pointer
	assign u.ptr_lo_nxt = u.incr ? u.ptr_lo + 8'h01
	                             : u.ptr_lo;
	assign page         = u.paged ? u.ptr_hi : LAST_PAGE;
	assign u.prog_addr  = {page, u.ptr_lo_nxt};
endmodule : lsx_ptr
